//--- fpe_cfg.svh
// Constants for the flash program/erase control registers.
// Assumes a byte-wide CPU register bus with 16-bit lower addresses.
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH

`define FPE_ADDR_MODE_CTRL    16'hffa8
`define FPE_ADDR_ERR_STATUS   16'hffa9
`define FPE_ADDR_BLK_LOW      16'hffaa
`define FPE_ADDR_BLK_HIGH     16'hffab
`define FPE_ADDR_SER_EXT_CTRL 16'hfdb4

`define FPE_BIT_PIN_MIRROR    7
`define FPE_BIT_SW_WE         6
`define FPE_BIT_ERASE_SETUP   5
`define FPE_BIT_PROG_SETUP    4
`define FPE_BIT_ERASE_VERIFY  3
`define FPE_BIT_PROG_VERIFY   2
`define FPE_BIT_ERASE_GO      1
`define FPE_BIT_PROG_GO       0
`define FPE_BIT_ERROR_FLAG    7
`define FPE_BIT_REG_ACCESS_EN 3

`define FPE_RESET_PIN_HIGH    8'h80
`define FPE_RESET_PIN_LOW     8'h00
`define FPE_RESET_ZERO        8'h00
`define FPE_BLK_HIGH_MASK     8'h03
`define FPE_READ_ZERO         8'h00
`define FPE_NUM_BLOCKS        10
`define FPE_FLASH_TOP         17'h1ffff

`endif

//--- fpe_pkg.sv
// Types for the flash program/erase control registers.
// Assumes fpe_cfg.svh is compiled with it.
package fpe_pkg;
  // ----------------------------------------
  // Bus request, mode outputs and bus states
  // ----------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpe_bus_req_s;

  typedef struct packed {
    logic erase_setup;
    logic program_setup;
    logic erase_verify;
    logic program_verify;
    logic erase_go;
    logic program_go;
  } fpe_modes_s;

  typedef enum logic [1:0] {
    FPE_IDLE,
    FPE_DATA
  } fpe_bus_state_e;
endpackage

//--- fpe_ctrl.sv
// Flash program/erase mode control, error status and erase-block select registers.
// Assumes a byte bus with two-state accesses; standby and error events come from the chip.
`timescale 1ns/1ps
`include "fpe_cfg.svh"

module fpe_ctrl (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          clk_en,
  // Chip state
  input  wire logic                          flash_write_enable_pin,
  input  wire logic                          hw_standby,
  input  wire logic                          sw_standby,
  input  wire logic                          flash_enabled,
  input  wire logic                          fault_event,
  // Register bus
  input  wire fpe_pkg::fpe_bus_req_s         bus_req,
  output logic [7:0]                         bus_rdata,
  output logic                               bus_done,
  // Flash array controls
  output fpe_pkg::fpe_modes_s                modes,
  output logic [`FPE_NUM_BLOCKS-1:0]         erase_block_sel,
  output logic                               flash_error_flag,
  output logic                               sw_write_enable
);
  import fpe_pkg::*;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= flash_write_enable_pin;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // Bus state: each access takes two states
  // ----------------------------------------
  fpe_bus_state_e bus_state;
  fpe_bus_state_e next_bus_state;
  logic [7:0]     next_bus_rdata;
  logic           access_en;
  logic [7:0]     mode_reg;
  logic [7:0]     blk_low;
  logic [7:0]     blk_high;
  logic [7:0]     ser_ext;
  logic           req;
  logic           wr_take;
  logic           reg_sel;

  assign req     = bus_req.rd | bus_req.wr;
  assign access_en = ser_ext[`FPE_BIT_REG_ACCESS_EN];
  assign reg_sel = access_en && flash_enabled && (bus_req.addr[15:2] == 14'(`FPE_ADDR_MODE_CTRL >> 2));
  assign wr_take = (bus_state == FPE_DATA) && bus_req.wr;
  assign bus_done = (bus_state == FPE_DATA);

  always_comb begin
    next_bus_state = bus_state;
    next_bus_rdata = `FPE_READ_ZERO;
    case (bus_state)
      FPE_IDLE: begin
        if (req) begin
          next_bus_state = FPE_DATA;
        end
      end
      default: begin
        next_bus_state = FPE_IDLE;
      end
    endcase
    if (req && bus_state == FPE_IDLE && bus_req.rd) begin
      if (bus_req.addr == `FPE_ADDR_SER_EXT_CTRL) begin
        next_bus_rdata = ser_ext;
      end else if (!reg_sel) begin
        next_bus_rdata = `FPE_READ_ZERO;
      end else if (bus_req.addr == `FPE_ADDR_MODE_CTRL) begin
        next_bus_rdata = mode_reg;
      end else if (bus_req.addr == `FPE_ADDR_ERR_STATUS) begin
        next_bus_rdata = {flash_error_flag, 7'h00};
      end else if (bus_req.addr == `FPE_ADDR_BLK_LOW) begin
        next_bus_rdata = blk_low;
      end else begin
        next_bus_rdata = blk_high;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= FPE_IDLE;
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      bus_state <= next_bus_state;
      bus_rdata <= next_bus_rdata;
    end
  end

  // ----------------------------------------
  // Register writes and protection
  // ----------------------------------------
  logic [7:0] next_mode_reg;
  logic [7:0] next_blk_low;
  logic [7:0] next_blk_high;
  logic [7:0] next_ser_ext;
  logic       next_err;
  logic       wr_mode;
  logic       wr_low;
  logic       wr_high;
  logic       swe;
  logic       any_standby;
  logic [9:0] sel_vec;

  assign any_standby = hw_standby | sw_standby;
  assign wr_mode = wr_take && reg_sel && bus_req.addr == `FPE_ADDR_MODE_CTRL;
  assign wr_low  = wr_take && reg_sel && bus_req.addr == `FPE_ADDR_BLK_LOW;
  assign wr_high = wr_take && reg_sel && bus_req.addr == `FPE_ADDR_BLK_HIGH;
  assign swe = mode_reg[`FPE_BIT_SW_WE];

  always_comb begin
    next_mode_reg = mode_reg;
    next_blk_low  = blk_low;
    next_blk_high = blk_high;
    next_ser_ext  = ser_ext;
    next_err      = flash_error_flag | fault_event;
    if (wr_take && bus_req.addr == `FPE_ADDR_SER_EXT_CTRL) begin
      next_ser_ext = bus_req.wdata;
    end
    if (wr_mode && pin_sync) begin
      next_mode_reg[`FPE_BIT_SW_WE] = bus_req.wdata[`FPE_BIT_SW_WE];
      if (swe) begin
        next_mode_reg[5:2] = bus_req.wdata[5:2];
        if (mode_reg[`FPE_BIT_ERASE_SETUP]) begin
          next_mode_reg[`FPE_BIT_ERASE_GO] = bus_req.wdata[`FPE_BIT_ERASE_GO];
        end
        if (mode_reg[`FPE_BIT_PROG_SETUP]) begin
          next_mode_reg[`FPE_BIT_PROG_GO] = bus_req.wdata[`FPE_BIT_PROG_GO];
        end
      end
    end
    next_mode_reg[`FPE_BIT_PIN_MIRROR] = pin_sync;
    if (!pin_sync) begin
      next_mode_reg = `FPE_RESET_PIN_LOW;
    end
    if (any_standby) begin
      next_mode_reg = pin_sync ? `FPE_RESET_PIN_HIGH : `FPE_RESET_PIN_LOW;
    end
    if (wr_low && swe) begin
      next_blk_low = bus_req.wdata;
    end
    if (wr_high && swe) begin
      next_blk_high = bus_req.wdata & `FPE_BLK_HIGH_MASK;
    end
    sel_vec = {next_blk_high[1:0], next_blk_low};
    if ($countones(sel_vec) > 1) begin
      next_blk_low  = `FPE_RESET_ZERO;
      next_blk_high = `FPE_RESET_ZERO;
    end
    if (any_standby || !pin_sync || !next_mode_reg[`FPE_BIT_SW_WE]) begin
      next_blk_low = `FPE_RESET_ZERO;
      next_blk_high[0] = 1'b0;
    end
    if (any_standby || !pin_sync) begin
      next_blk_high = `FPE_RESET_ZERO;
    end
    if (hw_standby) begin
      next_err = 1'b0;
    end
    if (next_err) begin
      next_mode_reg[1:0] = 2'b00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg         <= `FPE_RESET_PIN_LOW;
      blk_low          <= `FPE_RESET_ZERO;
      blk_high         <= `FPE_RESET_ZERO;
      ser_ext          <= `FPE_RESET_ZERO;
      flash_error_flag <= 1'b0;
    end else if (clk_en) begin
      mode_reg         <= next_mode_reg;
      blk_low          <= next_blk_low;
      blk_high         <= next_blk_high;
      ser_ext          <= next_ser_ext;
      flash_error_flag <= next_err;
    end
  end

  // ----------------------------------------
  // Outputs to the flash array
  // ----------------------------------------
  assign sw_write_enable = swe;
  assign modes = '{erase_setup:    mode_reg[`FPE_BIT_ERASE_SETUP],
                   program_setup:  mode_reg[`FPE_BIT_PROG_SETUP],
                   erase_verify:   mode_reg[`FPE_BIT_ERASE_VERIFY],
                   program_verify: mode_reg[`FPE_BIT_PROG_VERIFY],
                   erase_go:       mode_reg[`FPE_BIT_ERASE_GO],
                   program_go:     mode_reg[`FPE_BIT_PROG_GO]};
  logic [`FPE_NUM_BLOCKS-1:0] blk_all;

  assign blk_all = {blk_high[1:0], blk_low};

  // ----------------------------------------
  // One erase-select output per block
  // ----------------------------------------
  for (genvar g = 0; g < `FPE_NUM_BLOCKS; g++) begin : g_blk
    assign erase_block_sel[g] = blk_all[g];
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mirror_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en |=> mode_reg[7] == $past(pin_sync)) else $error("mode bit 7 does not follow pin");
  swe_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && !pin_sync) |=> !mode_reg[6]) else $error("software enable set with pin low");
  setup_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && !swe && !any_standby) |=> $stable(mode_reg[5:2]) || mode_reg[5:2] == 4'h0)
    else $error("setup bit changed without enable");
  erase_go_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $rose(mode_reg[1])) |-> $past(mode_reg[5] && swe && pin_sync)) else $error("erase go without setup");
  prog_go_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && $rose(mode_reg[0])) |-> $past(mode_reg[4] && swe && pin_sync)) else $error("program go without setup");
  err_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && flash_error_flag && !hw_standby) |=> flash_error_flag) else $error("error flag cleared early");
  err_protect_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    flash_error_flag |-> !modes.erase_go && !modes.program_go) else $error("go bit set under error protection");
  one_hot_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $countones(erase_block_sel) <= 1) else $error("more than one erase block selected");
  blk_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && !pin_sync) |=> erase_block_sel == 10'h000) else $error("block select kept with pin low");
  done_two_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && bus_state == FPE_IDLE && req) |=> bus_done) else $error("access not finished in two states");
  done_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && bus_done)
    |=> !bus_done) else $error("access held longer than two states");
  status_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && bus_state == FPE_IDLE && bus_req.rd && bus_req.addr == `FPE_ADDR_ERR_STATUS)
    |=> bus_rdata[6:0] == 7'h00) else $error("status low bits read nonzero");
  off_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && bus_state == FPE_IDLE && bus_req.rd && !flash_enabled && bus_req.addr != `FPE_ADDR_SER_EXT_CTRL)
    |=> bus_rdata == `FPE_READ_ZERO) else $error("read returned data with flash disabled");
  err_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && fault_event && !hw_standby)
    |=> flash_error_flag) else $error("fault did not set error flag");
  err_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && hw_standby)
    |=> !flash_error_flag) else $error("hardware standby kept error flag");
  standby_init_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && any_standby)
    |=> mode_reg == {$past(pin_sync), 7'h00}) else $error("standby did not reinitialize mode control");
  swe_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && !swe && !wr_mode)
    |=> erase_block_sel[8:0] == 9'h000) else $error("block select kept without software enable");
  refuse_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && wr_mode && pin_sync && !swe && !any_standby && !fault_event && !flash_error_flag)
    |=> mode_reg[5:0] == $past(mode_reg[5:0])) else $error("refused mode write changed a bit");
  access_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (clk_en && wr_take && !access_en && pin_sync && !any_standby && !fault_event && !flash_error_flag)
    |=> mode_reg[6:0] == $past(mode_reg[6:0]) && $stable(blk_low)) else $error("deselected write changed state");
  high_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    blk_high[7:2] == 6'h00) else $error("high block register upper bits set");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  cov_prog: cover property (@(posedge clk_sys) disable iff (!rst_b) modes.program_go);
  cov_erase: cover property (@(posedge clk_sys) disable iff (!rst_b) modes.erase_go);
  cov_err: cover property (@(posedge clk_sys) disable iff (!rst_b) flash_error_flag);
  cov_verify: cover property (@(posedge clk_sys) disable iff (!rst_b) modes.erase_verify || modes.program_verify);
  cov_standby: cover property (@(posedge clk_sys) disable iff (!rst_b) hw_standby || sw_standby);
endmodule // fpe_ctrl

//--- fpe_cpu_model.sv
// CPU software model issuing byte accesses to the flash control registers.
// Assumes the two-state handshake with a one-cycle bus_done.
`timescale 1ns/1ps

module fpe_cpu_model (
  // Clock
  input  wire logic             clk_sys,
  // Register bus
  output fpe_pkg::fpe_bus_req_s bus_req,
  input  wire logic [7:0]       bus_rdata,
  input  wire logic             bus_done
);
  import fpe_pkg::*;
  initial bus_req = '0;
  // One byte access held over both states; released address and data lines show inverted values, rd and wr go low.
  task automatic acc(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk_sys);
    bus_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bus_done !== 1'b1 && n < 8);
    q = bus_rdata;
    bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // fpe_cpu_model

//--- fpe_ctrl_tb_top.sv
// Self-checking bench for the flash control registers.
// Assumes fpe_pkg, fpe_cfg.svh and the CPU model are compiled first.
`timescale 1ns/1ps
`include "fpe_cfg.svh"

module fpe_ctrl_tb_top;
  import fpe_pkg::*;
  logic         clk_sys, rst_b, ce, pin, hw_sb, sw_sb, fen, fault, bus_done, err_flag, swe_out, err, acc_en;
  fpe_bus_req_s bus_req;
  fpe_modes_s   modes;
  logic [7:0]   bus_rdata, q, m, lo, r;
  logic [1:0]   hi;
  logic [9:0]   blk;
  int           num_errors = 0;
  int           comparisons = 0;
  int unsigned  seed = 82;
  int           seq[$] = '{'h20, 'h40, 'h41, 'h42, 'h50, 'h51, 'h40, 'h60, 'h62, 'h40, 'h48, 'h44, 'h40};

  fpe_ctrl u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(ce), .flash_write_enable_pin(pin),
    .hw_standby(hw_sb), .sw_standby(sw_sb), .flash_enabled(fen), .fault_event(fault), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_done(bus_done), .modes(modes), .erase_block_sel(blk),
    .flash_error_flag(err_flag), .sw_write_enable(swe_out));
  fpe_cpu_model u_cpu (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_done(bus_done));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fix();
    if (!pin) m = 8'h00;
    if (err) m[1:0] = 2'b00;
    if (!pin) {hi, lo} = 10'h000;
    if (!m[6]) begin
      lo = 8'h00;
      hi[0] = 1'b0;
    end
    if ($countones({hi, lo}) > 1) {hi, lo} = 10'h000;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] o;
    u_cpu.acc(1'b0, 1'b1, a, d, q);
    o = m;
    if (a == `FPE_ADDR_SER_EXT_CTRL) acc_en = d[3];
    else if (fen && acc_en && pin && a == `FPE_ADDR_MODE_CTRL) begin
      m[6] = d[6];
      if (o[6]) m[5:2] = d[5:2];
      if (o[6] && o[5]) m[1] = d[1];
      if (o[6] && o[4]) m[0] = d[0];
    end else if (fen && acc_en && o[6] && a == `FPE_ADDR_BLK_LOW) lo = d;
    else if (fen && acc_en && o[6] && a == `FPE_ADDR_BLK_HIGH) hi = d[1:0];
    fix();
  endtask

  task automatic check_all(input string name);
    for (int i = 0; i < 4; i++) begin
      u_cpu.acc(1'b1, 1'b0, `FPE_ADDR_MODE_CTRL + 16'(i), 8'h00, q);
      chk(q, !(fen && acc_en) ? 8'h00 : i == 0 ? {pin, m[6:0]} : i == 1 ? {err, 7'h00} : i == 2 ? lo : {6'h00, hi});
    end
    chk(modes, m[5:0]);
    chk(blk, {hi, lo});
    chk({err_flag, swe_out}, {err, m[6]});
    $display("test %s done", name);
  endtask

  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) fault <= 1'b1;
    else if (which == 1) sw_sb <= 1'b1;
    else hw_sb <= 1'b1;
    @(posedge clk_sys);
    {fault, sw_sb, hw_sb} <= 3'b000;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    pin = 1'b1;
    hw_sb = 1'b0;
    sw_sb = 1'b0;
    fen = 1'b1;
    ce = 1'b1;
    fault = 1'b0;
    {m, lo, hi, err, acc_en} = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check_all("locked");
    wr(`FPE_ADDR_SER_EXT_CTRL, 8'h08);
    check_all("reset_value");
    foreach (seq[i]) begin
      wr(`FPE_ADDR_MODE_CTRL, seq[i][7:0]);
      check_all("mode_step");
    end
    repeat (16) begin
      r = xs();
      wr(r[0] ? `FPE_ADDR_BLK_HIGH : `FPE_ADDR_BLK_LOW, r[0] ? {6'h00, r[2:1]} : r[1] ? 8'h01 << r[4:2] : xs());
      check_all("block_select");
    end
    @(posedge clk_sys);
    fen <= 1'b0;
    wr(`FPE_ADDR_MODE_CTRL, 8'h00);
    check_all("flash_off");
    fen <= 1'b1;
    wr(`FPE_ADDR_MODE_CTRL, 8'h50);
    wr(`FPE_ADDR_MODE_CTRL, 8'h51);
    pulse(0);
    err = 1'b1;
    fix();
    wr(`FPE_ADDR_MODE_CTRL, 8'h51);
    check_all("fault");
    pulse(1);
    {m, lo, hi} = '0;
    check_all("sw_standby");
    pulse(2);
    {m, lo, hi, err} = '0;
    wr(`FPE_ADDR_SER_EXT_CTRL, 8'h08);
    check_all("hw_standby");
    wr(`FPE_ADDR_MODE_CTRL, 8'h40);
    @(posedge clk_sys);
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    check_all("clock_hold");
    wr(`FPE_ADDR_BLK_HIGH, 8'h01);
    pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    fix();
    wr(`FPE_ADDR_MODE_CTRL, 8'h40);
    check_all("pin_low");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    {m, lo, hi, err, acc_en} = '0;
    repeat (4) @(posedge clk_sys);
    wr(`FPE_ADDR_SER_EXT_CTRL, 8'h08);
    check_all("reset_pin_low");
    pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check_all("pin_high");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
endmodule // fpe_ctrl_tb_top
